//--- src/gpt_consts.vh
/*
 * Constants of the general-purpose timer: widths, mode codes, channel modes and reset values.
 * Assumes it is included by its bare name from the timer design file.
 */
`ifndef GPT_CONSTS_VH
`define GPT_CONSTS_VH

`define GPT_CNT_W          16
`define GPT_PSC_W          16
`define GPT_ARR_RST        16'hffff
`define GPT_PSC_RST        16'h0000
`define GPT_CNT_RST        16'h0000
`define GPT_DIR_UP         2'h0
`define GPT_DIR_DOWN       2'h1
`define GPT_DIR_UPDOWN     2'h2
`define GPT_CH_CAPTURE     2'h0
`define GPT_CH_COMPARE     2'h1
`define GPT_CH_PWM         2'h2
`define GPT_CH_ONEPULSE    2'h3
`define GPT_CLK_INT        2'h0
`define GPT_CLK_LSE        2'h1
`define GPT_CLK_ENCODER    2'h2
`define GPT_CLK_HALL       2'h3

`endif

//--- src/gpt_timer.v
/*
 * General-purpose timer: prescaler, 16-bit auto-reload up/down/centre counter, up to four
 * capture/compare channels, encoder and hall-sensor counting in the four-channel variant, timer link, debug freeze.
 * Assumes a single 100 MHz clock; all pins and the low-speed external clock level are
 * synchronised here. Configuration arrives as plain inputs (no software bus in this block).
 * Parameter CHANNELS selects the variant: 4 for the four_channel_timer, 2 for
 * two_channel_timer_a and two_channel_timer_b.
 */
`timescale 1ns/1ps
`include "gpt_consts.vh"

module gpt_timer #(
  parameter CHANNELS = 4
) (
  // Clock and reset.
  input  wire                    clock,
  input  wire                    reset,
  // Counter configuration.
  input  wire                    enable,
  input  wire [1:0]              dir_mode,
  input  wire [1:0]              clk_source,
  input  wire [15:0]             prescale,
  input  wire [15:0]             auto_reload,
  input  wire                    one_shot,
  // Channel configuration, two bits of mode and sixteen of compare value per channel.
  input  wire [2*CHANNELS-1:0]   ch_mode,
  input  wire [16*CHANNELS-1:0]  ch_compare,
  input  wire [CHANNELS-1:0]     ch_polarity,
  // External pins, asynchronous.
  input  wire [CHANNELS-1:0]     ch_pin_in,
  input  wire                    low_speed_external_clock,
  input  wire [2:0]              hall_in,
  // Debug freeze.
  input  wire                    debug_halt,
  input  wire                    debug_freeze,
  // Timer link from and to other timers.
  input  wire                    link_trigger_in,
  input  wire                    link_chain_en,
  input  wire                    link_reset_en,
  output wire                    link_trigger_out,
  // Channel outputs and events.
  output wire [CHANNELS-1:0]     ch_out,
  output wire [CHANNELS-1:0]     ch_out_en,
  output wire [16*CHANNELS-1:0]  ch_capture,
  output wire [CHANNELS-1:0]     ch_flag,
  input  wire [CHANNELS-1:0]     ch_flag_clear,
  // Update and status.
  output wire [15:0]             count,
  output wire                    count_down,
  output wire                    update_flag,
  input  wire                    update_flag_clear,
  output wire                    update_irq,
  output wire                    dma_req
);

  localparam HAS_DMA = (CHANNELS == 4);

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Input synchronisers; the first stage feeds only the second stage.
  reg  [CHANNELS-1:0] pin_s1_ff;
  reg  [CHANNELS-1:0] pin_s2_ff;
  reg  [CHANNELS-1:0] pin_s3_ff;
  reg  [2:0]          hall_s1_ff;
  reg  [2:0]          hall_s2_ff;
  reg  [2:0]          hall_s3_ff;
  reg                 lse_s1_ff;
  reg                 lse_s2_ff;
  reg                 lse_s3_ff;

  always @(posedge clock) begin
    if (reset) begin
      pin_s1_ff  <= {CHANNELS{1'b0}};
      pin_s2_ff  <= {CHANNELS{1'b0}};
      pin_s3_ff  <= {CHANNELS{1'b0}};
      hall_s1_ff <= 3'h0;
      hall_s2_ff <= 3'h0;
      hall_s3_ff <= 3'h0;
      lse_s1_ff  <= 1'b0;
      lse_s2_ff  <= 1'b0;
      lse_s3_ff  <= 1'b0;
    end else begin
      pin_s1_ff  <= ch_pin_in;
      pin_s2_ff  <= pin_s1_ff;
      pin_s3_ff  <= pin_s2_ff;
      hall_s1_ff <= hall_in;
      hall_s2_ff <= hall_s1_ff;
      hall_s3_ff <= hall_s2_ff;
      lse_s1_ff  <= low_speed_external_clock;
      lse_s2_ff  <= lse_s1_ff;
      lse_s3_ff  <= lse_s2_ff;
    end
  end

  wire [CHANNELS-1:0] pin_rise = pin_s2_ff & ~pin_s3_ff;
  wire [CHANNELS-1:0] pin_fall = ~pin_s2_ff & pin_s3_ff;
  wire                lse_rise = lse_s2_ff & ~lse_s3_ff;
  wire                hall_chg = (hall_s2_ff != hall_s3_ff);

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Quadrature decode on channels 0 and 1: an edge of one phase alone is one count, direction
  // from the phase relation. Only the four-channel variant may select it.
  wire enc_a      = pin_s2_ff[0];
  wire enc_b      = pin_s2_ff[1 % CHANNELS];
  wire enc_a_chg  = pin_rise[0] | pin_fall[0];
  wire enc_b_chg  = pin_rise[1 % CHANNELS] | pin_fall[1 % CHANNELS];
  wire enc_step   = enc_a_chg ^ enc_b_chg;
  wire enc_down   = enc_a_chg ? (enc_a == enc_b) : (enc_a != enc_b);
  wire sel_enc    = HAS_DMA && (clk_source == `GPT_CLK_ENCODER);
  wire sel_hall   = HAS_DMA && (clk_source == `GPT_CLK_HALL);
  wire sel_lse    = !HAS_DMA && (clk_source == `GPT_CLK_LSE);

  // Tick source ahead of the prescaler; link chaining counts the other timer's trigger.
  reg src_tick;
  always @* begin
    if (link_chain_en) begin
      src_tick = link_trigger_in;
    end else if (sel_enc) begin
      src_tick = enc_step;
    end else if (sel_hall) begin
      src_tick = hall_chg;
    end else if (sel_lse) begin
      src_tick = lse_rise;
    end else begin
      src_tick = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Prescaler: the counter steps once per (prescale + 1) source ticks. A new ratio takes
  // effect at the next wrap of the prescaler, so a running period is never cut short.
  reg  [15:0] psc_cnt_ff;
  reg  [15:0] psc_live_ff;
  wire        frozen   = debug_halt & debug_freeze;
  wire        run      = enable & ~frozen;
  wire        psc_wrap = run & src_tick & (psc_cnt_ff == psc_live_ff);

  always @(posedge clock) begin
    if (reset) begin
      psc_cnt_ff  <= `GPT_PSC_RST;
      psc_live_ff <= `GPT_PSC_RST;
    end else if (run & src_tick) begin
      if (psc_wrap) begin
        psc_cnt_ff  <= 16'h0000;
        psc_live_ff <= prescale;
      end else begin
        psc_cnt_ff  <= psc_cnt_ff + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Main counter with reload at the auto-reload value or zero, and centre-aligned turnaround.
  reg  [15:0] cnt_ff;
  reg         down_ff;
  reg         upd_ff;
  reg         halted_ff;
  reg  [15:0] nxt_cnt;
  reg         nxt_down;
  reg         wrap;
  // Direction comes from the mode, or from the phase relation with the encoder, not from the last step,
  // so a switch from down to up never lets one stale downward step through.
  wire        step_down = sel_enc ? enc_down : (dir_mode == `GPT_DIR_DOWN);
  wire        link_rst  = link_reset_en & link_trigger_in;

  always @* begin
    nxt_cnt  = cnt_ff;
    nxt_down = down_ff;
    wrap     = 1'b0;
    if (dir_mode == `GPT_DIR_UPDOWN) begin
      if (!down_ff) begin
        if (cnt_ff >= auto_reload) begin
          nxt_down = 1'b1;
          nxt_cnt  = auto_reload - 16'h0001;
          wrap     = 1'b1;
        end else begin
          nxt_cnt  = cnt_ff + 16'h0001;
        end
      end else begin
        if (cnt_ff == 16'h0000) begin
          nxt_down = 1'b0;
          nxt_cnt  = 16'h0001;
          wrap     = 1'b1;
        end else begin
          nxt_cnt  = cnt_ff - 16'h0001;
        end
      end
    end else if (step_down) begin
      nxt_down = (dir_mode == `GPT_DIR_DOWN) | sel_enc;
      if (cnt_ff == 16'h0000) begin
        nxt_cnt = auto_reload;
        wrap    = 1'b1;
      end else begin
        nxt_cnt = cnt_ff - 16'h0001;
      end
    end else begin
      nxt_down = (dir_mode == `GPT_DIR_DOWN) & ~sel_enc;
      if (cnt_ff >= auto_reload) begin
        nxt_cnt = 16'h0000;
        wrap    = 1'b1;
      end else begin
        nxt_cnt = cnt_ff + 16'h0001;
      end
    end
  end

  wire cnt_step = psc_wrap & ~halted_ff;
  wire upd_evt  = cnt_step & wrap;

  // Counter, one-pulse stop and the update flag; a new update beats a clear in one cycle.
  always @(posedge clock) begin
    if (reset) begin
      cnt_ff    <= `GPT_CNT_RST;
      down_ff   <= 1'b0;
      upd_ff    <= 1'b0;
      halted_ff <= 1'b0;
    end else begin
      if (link_rst) begin
        cnt_ff    <= (dir_mode == `GPT_DIR_DOWN) ? auto_reload : 16'h0000;
        halted_ff <= 1'b0;
      end else if (cnt_step) begin
        cnt_ff  <= nxt_cnt;
        down_ff <= nxt_down;
        if (wrap & one_shot) begin
          halted_ff <= 1'b1;
        end
      end else if (!enable) begin
        halted_ff <= 1'b0;
      end
      if (upd_evt) begin
        upd_ff <= 1'b1;
      end else if (update_flag_clear) begin
        upd_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Capture/compare channels, one per generate step.
  reg  [CHANNELS-1:0] out_ff;
  reg  [CHANNELS-1:0] flag_ff;
  reg  [CHANNELS-1:0] trig_ff;
  reg  [15:0]         cap_ff [0:CHANNELS-1];
  genvar gi;
  generate
    for (gi = 0; gi < CHANNELS; gi = gi + 1) begin : g_ch
      wire [1:0]  mode  = ch_mode[2*gi +: 2];
      wire [15:0] cmp   = ch_compare[16*gi +: 16];
      wire        is_in = (mode == `GPT_CH_CAPTURE);
      wire        edge_hit = ch_polarity[gi] ? pin_fall[gi] : pin_rise[gi];
      wire        match = cnt_step & (nxt_cnt == cmp);
      wire        evt   = is_in ? edge_hit : match;
      // Output level for each channel mode.
      reg         nxt_out;
      always @* begin
        nxt_out = out_ff[gi];
        case (mode)
          `GPT_CH_COMPARE:  nxt_out = match ? ~out_ff[gi] : out_ff[gi];
          `GPT_CH_PWM:      nxt_out = (nxt_cnt < cmp) ^ ch_polarity[gi];
          `GPT_CH_ONEPULSE: nxt_out = ((nxt_cnt >= cmp) & ~halted_ff) ^ ch_polarity[gi];
          default:          nxt_out = 1'b0;
        endcase
      end
      always @(posedge clock) begin
        if (reset) begin
          out_ff[gi]  <= 1'b0;
          flag_ff[gi] <= 1'b0;
          trig_ff[gi] <= 1'b0;
          cap_ff[gi]  <= 16'h0000;
        end else begin
          trig_ff[gi] <= evt;
          if (is_in) begin
            out_ff[gi] <= 1'b0;
          end else if (cnt_step | link_rst) begin
            out_ff[gi] <= nxt_out;
          end
          if (is_in & edge_hit) begin
            cap_ff[gi] <= cnt_ff;
          end
          if (evt) begin
            flag_ff[gi] <= 1'b1;
          end else if (ch_flag_clear[gi]) begin
            flag_ff[gi] <= 1'b0;
          end
        end
      end
      assign ch_capture[16*gi +: 16] = cap_ff[gi];
      assign ch_out_en[gi] = ~is_in;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Link output, DMA request and status; registered one cycle after the event.
  reg upd_pulse_ff;
  always @(posedge clock) begin
    if (reset) begin
      upd_pulse_ff <= 1'b0;
    end else begin
      upd_pulse_ff <= upd_evt;
    end
  end

  assign link_trigger_out = upd_pulse_ff;
  assign dma_req          = HAS_DMA ? (upd_pulse_ff | (|trig_ff)) : 1'b0;
  assign ch_out           = out_ff;
  assign ch_flag          = flag_ff;
  assign count            = cnt_ff;
  assign count_down       = down_ff;
  assign update_flag      = upd_ff;
  assign update_irq       = upd_ff;

endmodule // gpt_timer

//--- verif/gpt_timer_asserts.sv
/* Port checker for the timer, bound into gpt_timer.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
module gpt_timer_chk #(
  parameter CHANNELS = 4
) (
  // Clock and reset.
  input wire        clock,
  input wire        reset,
  // Counter set-up.
  input wire        enable,
  input wire [1:0]  dir_mode,
  input wire [1:0]  clk_source,
  input wire [15:0] prescale,
  input wire [15:0] auto_reload,
  input wire        debug_halt,
  input wire        debug_freeze,
  // Counter state and events.
  input wire [15:0] count,
  input wire        update_flag,
  input wire        update_flag_clear,
  input wire        update_irq,
  input wire        link_trigger_out,
  input wire        dma_req
);
  default clocking gpt_cb @(posedge clock);
  endclocking
  default disable iff (reset);

  // A plain run steps once per edge; prescale must already be zero when it was loaded.
  wire run = enable && clk_source == 2'h0 && prescale == 16'h0 && !(debug_halt && debug_freeze);

  //////////////////////////////////////////////////////////////////////////////
  a_irq_mirror: assert property (update_irq == update_flag)
    else $error("interrupt differs from update flag");
  a_up_step: assert property (
    run && dir_mode == 2'h0 && count < auto_reload |=> count == $past(count) + 16'h1)
    else $error("up count did not step by one");
  a_up_wrap: assert property (
    run && dir_mode == 2'h0 && count == auto_reload |=> count == 16'h0 && update_flag)
    else $error("up wrap wrong");
  a_down_wrap: assert property (
    run && dir_mode == 2'h1 && count == 16'h0 |=> count == $past(auto_reload) && update_flag)
    else $error("down wrap wrong");
  a_link_after: assert property ($rose(update_flag) |-> link_trigger_out)
    else $error("no link pulse with update");
  a_dma_after: assert property ($rose(update_flag) |-> dma_req || CHANNELS == 2)
    else $error("no dma request with update");
  a_freeze_hold: assert property (debug_halt && debug_freeze |=> $stable(count))
    else $error("count moved while frozen");
  a_flag_sticky: assert property (update_flag && !update_flag_clear |=> update_flag)
    else $error("update flag dropped alone");
  // Main scenarios seen.
  c_update: cover property ($rose(update_flag));
  c_frozen: cover property (enable && debug_halt && debug_freeze);
  c_down: cover property (run && dir_mode == 2'h1 && count == 16'h0);
endmodule // gpt_timer_chk

bind gpt_timer gpt_timer_chk #(.CHANNELS(CHANNELS)) gpt_timer_chk_inst (
  .clock(clock), .reset(reset), .enable(enable), .dir_mode(dir_mode),
  .clk_source(clk_source), .prescale(prescale), .auto_reload(auto_reload),
  .debug_halt(debug_halt), .debug_freeze(debug_freeze), .count(count),
  .update_flag(update_flag), .update_flag_clear(update_flag_clear),
  .update_irq(update_irq), .link_trigger_out(link_trigger_out), .dma_req(dma_req)
);

//--- verif/gpt_pins_model.sv
/* Far-side pins: capture pin, hall sensors, slow clock, link pulses.
   Assumes the bench toggles pin_req 1 ns after an edge. */
`timescale 1ns/1ps
module gpt_pins_model (
  // Clock and bench requests.
  input  wire       clock,
  input  wire       pin_req,
  input  wire       slow,
  // Pins toward the timer.
  output reg  [3:0] ch_pin,
  output reg        lse_level,
  output reg  [2:0] hall,
  output reg        link_pulse
);
  integer wait_cnt = 0;
  integer tick_cnt = 0;
  reg     req_now;
  reg     slow_now;

  // Pin 0 follows the request at once or after a four-cycle stall; pins 1 to 3 stay low, the rest run free.
  // Requests are read on the edge itself, so the bench's own 1 ns update never races us.
  always @(posedge clock) begin
    req_now = pin_req;
    slow_now = slow;
    #1;
    tick_cnt = tick_cnt + 1;
    if (ch_pin[0] == req_now)
      wait_cnt = slow_now ? 4 : 0;
    else if (wait_cnt > 0)
      wait_cnt = wait_cnt - 1;
    else
      ch_pin[0] = req_now;
    if (tick_cnt % 8 == 0)
      lse_level = !lse_level;
    if (tick_cnt % 16 == 0)
      hall = {hall[1:0], !hall[2]}; // Six-state code as three sensors give.
    link_pulse = (tick_cnt % 32 == 0);
  end

  initial begin
    ch_pin = 4'h0;
    lse_level = 1'h0;
    hall = 3'h1;
    link_pulse = 1'h0;
  end
endmodule // gpt_pins_model

//--- verif/gpt_timer_tb.sv
/* Self-checking bench for the four-channel timer and its pin model.
   Assumes the checker binds itself; inputs move 1 ns after a rising edge. */
`timescale 1ns/1ps
module gpt_timer_tb;
  reg         clock = 1'h0;
  reg         reset = 1'h1;
  reg         enable = 1'h0;
  reg  [1:0]  dir_mode = 2'h0;
  reg  [1:0]  clk_source = 2'h0;
  reg  [15:0] prescale = 16'h0;
  reg  [15:0] auto_reload = 16'h2;
  reg  [7:0]  ch_mode = 8'he4;
  reg  [3:0]  ch_flag_clear = 4'h0;
  reg         debug_halt = 1'h0;
  reg         debug_freeze = 1'h0;
  reg         update_flag_clear = 1'h0;
  reg         pin_req = 1'h0;
  reg         slow = 1'h0;
  reg         one_shot = 1'h0;
  reg  [63:0] ch_compare = 64'h0;
  reg  [3:0]  ch_polarity = 4'h0;
  reg         link_chain_en = 1'h0;
  reg         link_reset_en = 1'h0;
  reg  [15:0] v;
  wire [3:0]  pin_w, ch_out, ch_out_en, ch_flag;
  wire [63:0] ch_capture;
  wire [15:0] count;
  wire [2:0]  hall_w;
  wire        lse_w, link_w, link_trigger_out, count_down, update_flag, update_irq, dma_req;
  integer     error_cnt = 0;
  integer     num_checks = 0;
  integer     i;

  // Clock at 100 MHz.
  always #5 clock = !clock;

  //////////////////////////////////////////////////////////////////////////////
  gpt_timer #(.CHANNELS(4)) gpt_timer_inst (
    .clock(clock), .reset(reset), .enable(enable), .dir_mode(dir_mode),
    .clk_source(clk_source), .prescale(prescale), .auto_reload(auto_reload),
    .one_shot(one_shot), .ch_mode(ch_mode), .ch_compare(ch_compare), .ch_polarity(ch_polarity),
    .ch_pin_in(pin_w), .low_speed_external_clock(lse_w), .hall_in(hall_w),
    .debug_halt(debug_halt), .debug_freeze(debug_freeze), .link_trigger_in(link_w),
    .link_chain_en(link_chain_en), .link_reset_en(link_reset_en),
    .link_trigger_out(link_trigger_out),
    .ch_out(ch_out), .ch_out_en(ch_out_en), .ch_capture(ch_capture), .ch_flag(ch_flag),
    .ch_flag_clear(ch_flag_clear), .count(count), .count_down(count_down),
    .update_flag(update_flag), .update_flag_clear(update_flag_clear),
    .update_irq(update_irq), .dma_req(dma_req));
  gpt_pins_model gpt_pins_model_inst (
    .clock(clock), .pin_req(pin_req), .slow(slow), .ch_pin(pin_w),
    .lse_level(lse_w), .hall(hall_w), .link_pulse(link_w));

  //////////////////////////////////////////////////////////////////////////////
  // Step to 1 ns after the n-th rising edge, so inputs never race the edge.
  task tick(input integer n);
    begin
      repeat (n) @(posedge clock);
      #1;
    end
  endtask

  // Compare and count.
  task chk(input [15:0] got, input [15:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        error_cnt = error_cnt + 1;
      end
    end
  endtask

  // Halt the count and clear the sticky update flag.
  task stop;
    begin
      enable = 1'h0;
      update_flag_clear = 1'h1;
      tick(1);
      update_flag_clear = 1'h0;
      chk(update_flag, 1'h0);
    end
  endtask

  task t_up_wrap;
    begin
      enable = 1'h1;
      tick(2);
      chk(count, 16'h2);
      tick(1);
      chk(count, 16'h0);
      chk(update_flag, 1'h1);
      // Link pulse and DMA request are launched on the same edge as the flag.
      chk(link_trigger_out, 1'h1);
      chk(dma_req, 1'h1);
      tick(1);
      chk(link_trigger_out, 1'h0);
      stop;
      $display("up wrap test done");
    end
  endtask

  task t_down;
    begin
      dir_mode = 2'h1;
      auto_reload = 16'h3;
      enable = 1'h1;
      // The count was left at one, so a single downward step reaches zero.
      tick(1);
      chk(count, 16'h0);
      chk(count_down, 1'h1);
      tick(1);
      chk(count, 16'h3);
      chk(update_flag, 1'h1);
      stop;
      $display("down wrap test done");
    end
  endtask

  task t_freeze;
    begin
      dir_mode = 2'h0;
      auto_reload = 16'h00ff;
      debug_halt = 1'h1;
      debug_freeze = 1'h1;
      enable = 1'h1;
      tick(4);
      chk(count, 16'h3);
      debug_freeze = 1'h0;
      tick(1);
      chk(count, 16'h4);
      clk_source = 2'h1;
      tick(20);
      // The four-channel variant ignores the slow clock and keeps counting every edge.
      chk(count, 16'h18);
      clk_source = 2'h0;
      debug_halt = 1'h0;
      $display("freeze test done");
    end
  endtask

  task t_capture;
    begin
      chk(ch_out_en, 4'he);
      pin_req = 1'h1;
      for (i = 0; i < 20 && pin_w[0] !== 1'h1; i = i + 1) @(negedge clock);
      v = count;
      tick(3);
      chk(ch_flag[0], 1'h1);
      chk(ch_capture[15:0], v + 16'h2);
      slow = 1'h1;
      ch_flag_clear = 4'h1;
      tick(1);
      ch_flag_clear = 4'h0;
      pin_req = 1'h0;
      tick(12);
      chk(pin_w[0], 1'h0);
      chk(ch_flag[0], 1'h0);
      $display("capture test done");
    end
  endtask

  // PWM on channel 2 is high while the count is below compare, inverted by polarity.
  task t_pwm;
    begin
      ch_compare = {16'h0000, 16'h0002, 16'h0001, 16'h0000};
      auto_reload = 16'h3;
      for (i = 0; i < 4; i = i + 1) begin
        tick(1);
        chk(ch_out[2], (count < 16'h2) ? 16'h1 : 16'h0);
      end
      ch_polarity = 4'h4;
      tick(1);
      chk(ch_out[2], (count < 16'h2) ? 16'h0 : 16'h1);
      ch_polarity = 4'h0;
      auto_reload = 16'h00ff;
      $display("pwm test done");
    end
  endtask

  task t_prescale;
    begin
      prescale = 16'h3;
      v = count;
      for (i = 0; i < 20 && count === v; i = i + 1) @(negedge clock);
      v = count;
      tick(3);
      chk(count, v);
      tick(1);
      chk(count, v + 16'h1);
      // A link pulse with reset enabled returns the count to zero.
      link_reset_en = 1'h1;
      @(negedge clock);
      for (i = 0; i < 40 && link_w !== 1'h1; i = i + 1) @(negedge clock);
      tick(1);
      chk(count, 16'h0);
      link_reset_en = 1'h0;
      $display("prescale test done");
    end
  endtask

  // Print the counts and the verdict, then end the run.
  task close_out;
    begin
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask

  // Main sequence after 16 cycles of reset.
  initial begin
    tick(16);
    reset = 1'h0;
    t_up_wrap;
    t_down;
    t_freeze;
    t_capture;
    t_pwm;
    t_prescale;
    close_out;
  end

  // Watchdog far beyond the hundred or so cycles the tests need.
  initial begin
    #20000;
    error_cnt = error_cnt + 1;
    close_out;
  end
endmodule // gpt_timer_tb
